/* rtl/filt_pkg.sv */
// Summary of operation
// - Detect resonance only between 250 and 1500 Hz.
// - Current path: lowpass then three notch stages.
// - Suppression on by default in auto modes.
// - One-button config bit 1 gates suppression.
// - Real-time config bit 6 gates suppression.
// - Mode 1 one-button, 3 real-time, 0 manual.
// - One-button success writes notches two to four.
// - Auto-enabled notch stays until switched off.
// - Activation setting removes any notch stage.
// - Real-time tracking updates only notch two.
// - Notch frequencies 0.5 to 16000 Hz, default 1000.
// - Notch dampings: denominator 0.3, numerator 0.01 default.
// - Position filter 0.5-62.5 Hz, internal positioning only.
// - Vibration enable: 0 off, 1 on, reset 0.
// - Vibration type: 0 rugged, 1 sensitive, reset 0.
// - Vibration frequency default 1 Hz, damping 0.03.
// - Mode 5 restores notch, activation and lowpass defaults, mode 0 keeps them.
package filt_pkg;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_OBCFG = 8'h04;
    localparam logic [7:0] A_RTCFG = 8'h08;
    localparam logic [7:0] A_ACT = 8'h0C;
    localparam logic [7:0] A_LPCOEF = 8'h10;
    localparam logic [7:0] A_NOTCH = 8'h20;
    localparam logic [7:0] A_NOTCH_END = 8'h4C;
    localparam logic [7:0] A_VEN = 8'h50;
    localparam logic [7:0] A_VTYPE = 8'h54;
    localparam logic [7:0] A_VFREQ = 8'h58;
    localparam logic [7:0] A_VDAMP = 8'h5C;
    localparam logic [7:0] A_CMODE = 8'h60;
    localparam logic [7:0] A_STAT = 8'h64;
    localparam logic [7:0] A_DET = 8'h68;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_OB = 3'h1;
    localparam logic [2:0] MODE_RT = 3'h3;
    localparam logic [2:0] MODE_DEF = 3'h5;
    localparam int OB_SUPP_BIT = 1;
    localparam int RT_SUPP_BIT = 6;
    localparam logic [15:0] OBCFG_RST = 16'h0002;
    localparam logic [15:0] RTCFG_RST = 16'h004C;
    localparam logic [3:0] ACT_RST = 4'h1;
    localparam logic [15:0] LP_RST = 16'h7FFF;
    // Frequencies count half hertz, notch dampings thousandths, vibration damping hundredths.
    localparam logic [15:0] NF_RST = 16'h07D0;
    localparam logic [13:0] DD_RST = 14'h012C;
    localparam logic [13:0] DN_RST = 14'h000A;
    localparam logic [15:0] BAND_LO = 16'h01F4;
    localparam logic [15:0] BAND_HI = 16'h0BB8;
    localparam logic [7:0] VF_RST = 8'h02;
    localparam logic [6:0] VD_RST = 7'h03;
    localparam logic [7:0] CM_INT_POS = 8'h01;
    localparam logic [7:0] CM_RST = 8'h00;
    localparam int unsigned PI_2P24 = 52707179;
    localparam int unsigned NOTCH_DAMP_K = 131;
    localparam int unsigned VIB_DAMP_K = 1311;

    typedef struct packed {
        logic [15:0] den_f;
        logic [13:0] den_d;
        logic [15:0] num_f;
        logic [13:0] num_d;
    } notch_cfg_type;

    localparam notch_cfg_type NOTCH_RST = '{den_f: NF_RST, den_d: DD_RST,
                                           num_f: NF_RST, num_d: DN_RST};

    typedef struct packed {
        notch_cfg_type [2:0] notch;
        logic [15:0] lp_coef;
        logic [3:0] act;
        logic [7:0] vib_f;
        logic [6:0] vib_d;
        logic vib_type;
        logic vib_en;
        logic [7:0] cmode;
    } cfg_type;

    typedef struct packed {
        logic valid;
        logic signed [15:0] data;
    } sample_type;

    typedef struct packed {
        logic valid;
        logic [15:0] freq;
    } det_type;
endpackage

/* rtl/servo_filters.sv */
`timescale 1ns/1ps
module servo_filters #(
    parameter int unsigned CUR_RATE_HZ = 16000,
    parameter int unsigned POS_RATE_HZ = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire filt_pkg::sample_type spd_in,
    input wire filt_pkg::sample_type pos_in,
    input wire filt_pkg::det_type det,
    input wire logic ob_done,
    input wire logic ob_ok,
    output filt_pkg::sample_type cur_out,
    output filt_pkg::sample_type pos_out
);
    localparam int unsigned CUR_K = filt_pkg::PI_2P24 / CUR_RATE_HZ;
    localparam int unsigned POS_K = filt_pkg::PI_2P24 / POS_RATE_HZ;

    typedef struct packed {
        filt_pkg::cfg_type cfg;
        filt_pkg::cfg_type act_cfg;
        filt_pkg::notch_cfg_type [2:0] shadow;
        logic [2:0] pend;
        logic [1:0] slot;
        logic [2:0] mode;
        logic [15:0] obcfg;
        logic [15:0] rtcfg;
        logic [15:0] det_f;
        logic signed [15:0] lp_y;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        filt_pkg::sample_type cur;
        filt_pkg::sample_type pos;
    } top_state_type;

    top_state_type st, nx;
    logic wr_en, supp;
    logic signed [47:0] lp_acc;
    logic signed [15:0] lp_out;
    logic signed [15:0] chain [0:3];
    logic signed [15:0] vib_y;
    logic vib_bypass;
    logic [13:0] vib_dd, vib_dn;

    function automatic logic in_band(input logic [15:0] f);
        in_band = (f >= filt_pkg::BAND_LO) && (f <= filt_pkg::BAND_HI);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && ((a <= filt_pkg::A_LPCOEF) ||
                 ((a >= filt_pkg::A_NOTCH) && (a <= filt_pkg::A_NOTCH_END)) ||
                 ((a >= filt_pkg::A_VEN) && (a <= filt_pkg::A_DET)));
    endfunction

    function automatic filt_pkg::notch_cfg_type auto_notch(input logic [15:0] f);
        auto_notch = '{den_f: f, den_d: filt_pkg::DD_RST,
                       num_f: f, num_d: filt_pkg::DN_RST};
    endfunction

    assign wr_en = psel && penable && st.pready && pwrite && !st.pslverr;
    assign supp = ((st.mode == filt_pkg::MODE_OB) && st.obcfg[filt_pkg::OB_SUPP_BIT]) ||
                  ((st.mode == filt_pkg::MODE_RT) && st.rtcfg[filt_pkg::RT_SUPP_BIT]);

    // First stage of the current path is a first-order lowpass.
    always_comb begin
        lp_acc = 48'(st.lp_y) + ((48'($signed({1'b0, st.act_cfg.lp_coef})) *
                 (48'(spd_in.data) - 48'(st.lp_y))) >>> 15);
        lp_out = st.act_cfg.act[0] ? lp_acc[15:0] : spd_in.data;
    end
    assign chain[0] = lp_out;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_notch
            svf_stage #(
                .FREQ_K(CUR_K),
                .DAMP_K(filt_pkg::NOTCH_DAMP_K)
            ) u_notch (
                .pclk(pclk),
                .presetn(presetn),
                .en(spd_in.valid),
                .bypass(!st.act_cfg.act[i+1]),
                .x(chain[i]),
                .freq(st.act_cfg.notch[i].den_f),
                .dden(st.act_cfg.notch[i].den_d),
                .dnum(st.act_cfg.notch[i].num_d),
                .y(chain[i+1])
            );
        end
    endgenerate

    // Rugged keeps a shallow notch that tolerates frequency error; sensitive cuts deep.
    assign vib_dd = {7'h00, st.act_cfg.vib_d};
    assign vib_dn = st.act_cfg.vib_type ? 14'h0000 : {9'h000, st.act_cfg.vib_d[6:2]};
    assign vib_bypass = !(st.act_cfg.vib_en && (st.act_cfg.cmode == filt_pkg::CM_INT_POS));

    svf_stage #(
        .FREQ_K(POS_K),
        .DAMP_K(filt_pkg::VIB_DAMP_K)
    ) u_vib (
        .pclk(pclk),
        .presetn(presetn),
        .en(pos_in.valid),
        .bypass(vib_bypass),
        .x(pos_in.data),
        .freq({8'h00, st.act_cfg.vib_f}),
        .dden(vib_dd),
        .dnum(vib_dn),
        .y(vib_y)
    );

    always_comb begin
        nx = st;
        // Zero-wait slave: ready rises for the access cycle of every transfer.
        nx.pready = psel && !penable;
        nx.pslverr = psel && !penable && !mapped(paddr);
        nx.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                filt_pkg::A_MODE: nx.prdata = {29'h0, st.mode};
                filt_pkg::A_OBCFG: nx.prdata = {16'h0, st.obcfg};
                filt_pkg::A_RTCFG: nx.prdata = {16'h0, st.rtcfg};
                filt_pkg::A_ACT: nx.prdata = {28'h0, st.cfg.act};
                filt_pkg::A_LPCOEF: nx.prdata = {16'h0, st.cfg.lp_coef};
                filt_pkg::A_VEN: nx.prdata = {31'h0, st.cfg.vib_en};
                filt_pkg::A_VTYPE: nx.prdata = {31'h0, st.cfg.vib_type};
                filt_pkg::A_VFREQ: nx.prdata = {24'h0, st.cfg.vib_f};
                filt_pkg::A_VDAMP: nx.prdata = {25'h0, st.cfg.vib_d};
                filt_pkg::A_CMODE: nx.prdata = {24'h0, st.cfg.cmode};
                filt_pkg::A_STAT: nx.prdata = {26'h0, supp, st.slot, st.pend};
                filt_pkg::A_DET: nx.prdata = {16'h0, st.det_f};
                default: begin
                    if (mapped(paddr) && paddr >= filt_pkg::A_NOTCH) begin
                        case (paddr[3:2])
                            2'h0: nx.prdata = {16'h0, st.cfg.notch[paddr[5:4] - 2'h2].den_f};
                            2'h1: nx.prdata = {18'h0, st.cfg.notch[paddr[5:4] - 2'h2].den_d};
                            2'h2: nx.prdata = {16'h0, st.cfg.notch[paddr[5:4] - 2'h2].num_f};
                            default: nx.prdata = {18'h0, st.cfg.notch[paddr[5:4] - 2'h2].num_d};
                        endcase
                    end
                end
            endcase
        end
        if (wr_en) begin
            case (paddr)
                filt_pkg::A_MODE: begin
                    if (pwdata[2:0] inside {filt_pkg::MODE_OFF, filt_pkg::MODE_OB,
                                            filt_pkg::MODE_RT, filt_pkg::MODE_DEF}) begin
                        nx.mode = pwdata[2:0];
                        nx.pend = 3'h0;
                        nx.slot = 2'h0;
                    end
                    if (pwdata[2:0] == filt_pkg::MODE_DEF) begin
                        nx.cfg.notch = {3{filt_pkg::NOTCH_RST}};
                        nx.cfg.act = filt_pkg::ACT_RST;
                        nx.cfg.lp_coef = filt_pkg::LP_RST;
                    end
                end
                filt_pkg::A_OBCFG: nx.obcfg = pwdata[15:0];
                filt_pkg::A_RTCFG: nx.rtcfg = pwdata[15:0];
                filt_pkg::A_ACT: nx.cfg.act = pwdata[3:0];
                filt_pkg::A_LPCOEF: nx.cfg.lp_coef = pwdata[15:0];
                filt_pkg::A_VEN: nx.cfg.vib_en = pwdata[0];
                filt_pkg::A_VTYPE: nx.cfg.vib_type = pwdata[0];
                filt_pkg::A_VFREQ: nx.cfg.vib_f = pwdata[7:0];
                filt_pkg::A_VDAMP: nx.cfg.vib_d = pwdata[6:0];
                filt_pkg::A_CMODE: nx.cfg.cmode = pwdata[7:0];
                default: begin
                    if (paddr >= filt_pkg::A_NOTCH && paddr <= filt_pkg::A_NOTCH_END) begin
                        case (paddr[3:2])
                            2'h0: nx.cfg.notch[paddr[5:4] - 2'h2].den_f = pwdata[15:0];
                            2'h1: nx.cfg.notch[paddr[5:4] - 2'h2].den_d = pwdata[13:0];
                            2'h2: nx.cfg.notch[paddr[5:4] - 2'h2].num_f = pwdata[15:0];
                            default: nx.cfg.notch[paddr[5:4] - 2'h2].num_d = pwdata[13:0];
                        endcase
                    end
                end
            endcase
        end
        if (ob_done && st.mode == filt_pkg::MODE_OB) begin
            if (ob_ok && supp) begin
                for (int n = 0; n < 3; n++) begin
                    if (st.pend[n]) begin
                        nx.cfg.notch[n] = st.shadow[n];
                    end
                end
                nx.cfg.act[3:1] = nx.cfg.act[3:1] | st.pend;
            end
            nx.pend = 3'h0;
            nx.slot = 2'h0;
        end
        // Detections come after every clear, so one in the cycle of a clear is never lost.
        if (det.valid && in_band(det.freq) && supp) begin
            nx.det_f = det.freq;
            if (st.mode == filt_pkg::MODE_RT) begin
                nx.cfg.notch[0] = auto_notch(det.freq);
                nx.cfg.act[1] = 1'b1;
            end else if (nx.slot != 2'h3) begin
                nx.shadow[nx.slot] = auto_notch(det.freq);
                nx.pend[nx.slot] = 1'b1;
                nx.slot = nx.slot + 2'h1;
            end
        end
        // Settings reach the filters only in cycles that carry no sample.
        if (!spd_in.valid && !pos_in.valid) begin
            nx.act_cfg = st.cfg;
        end
        nx.cur.valid = spd_in.valid;
        nx.pos.valid = pos_in.valid;
        if (spd_in.valid) begin
            nx.lp_y = st.act_cfg.act[0] ? lp_acc[15:0] : spd_in.data;
            nx.cur.data = chain[3];
        end
        if (pos_in.valid) begin
            nx.pos.data = vib_y;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg.notch <= {3{filt_pkg::NOTCH_RST}};
            st.cfg.lp_coef <= filt_pkg::LP_RST;
            st.cfg.act <= filt_pkg::ACT_RST;
            st.cfg.vib_f <= filt_pkg::VF_RST;
            st.cfg.vib_d <= filt_pkg::VD_RST;
            st.cfg.cmode <= filt_pkg::CM_RST;
            st.act_cfg.notch <= {3{filt_pkg::NOTCH_RST}};
            st.act_cfg.lp_coef <= filt_pkg::LP_RST;
            st.act_cfg.act <= filt_pkg::ACT_RST;
            st.act_cfg.vib_f <= filt_pkg::VF_RST;
            st.act_cfg.vib_d <= filt_pkg::VD_RST;
            st.act_cfg.cmode <= filt_pkg::CM_RST;
            st.obcfg <= filt_pkg::OBCFG_RST;
            st.rtcfg <= filt_pkg::RTCFG_RST;
        end else begin
            st <= nx;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign cur_out = st.cur;
    assign pos_out = st.pos;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_keep_act;
        !(wr_en && (paddr == filt_pkg::A_ACT || paddr == filt_pkg::A_MODE));
    endsequence

    a_band_gate: assert property (det.valid && !in_band(det.freq) && !wr_en && !ob_done
        |=> st.cfg.notch == $past(st.cfg.notch)) else $error("out-of-band detection used");
    a_rt_track: assert property (st.mode == filt_pkg::MODE_RT && supp && det.valid &&
        in_band(det.freq) |=> st.cfg.notch[0].den_f == $past(det.freq) && st.cfg.act[1])
        else $error("real-time notch not tracked");
    a_rt_only_n2: assert property (st.mode == filt_pkg::MODE_RT && !wr_en
        |=> st.cfg.notch[2:1] == $past(st.cfg.notch[2:1])) else $error("stage 3/4 touched");
    a_ob_gate: assert property (st.mode == filt_pkg::MODE_OB &&
        !st.obcfg[filt_pkg::OB_SUPP_BIT] && det.valid && !ob_done && !wr_en
        |=> st.pend == $past(st.pend))
        else $error("one-button suppression not gated");
    a_rt_gate: assert property (st.mode == filt_pkg::MODE_RT &&
        !st.rtcfg[filt_pkg::RT_SUPP_BIT] && !wr_en |=> st.cfg == $past(st.cfg))
        else $error("real-time suppression not gated");
    a_ob_commit: assert property (st.mode == filt_pkg::MODE_OB && ob_done && ob_ok && supp &&
        !det.valid |=> (st.cfg.act[3:1] & $past(st.pend)) == $past(st.pend) && st.pend == 3'h0)
        else $error("one-button result not committed");
    a_notch_keep: assert property (st.cfg.act[1] and s_keep_act
        |=> st.cfg.act[1]) else $error("auto notch dropped");
    a_act_write: assert property (wr_en && paddr == filt_pkg::A_ACT && !det.valid && !ob_done
        |=> st.cfg.act == $past(pwdata[3:0])) else $error("activation write lost");
    a_mode5_def: assert property (wr_en && paddr == filt_pkg::A_MODE &&
        pwdata[2:0] == filt_pkg::MODE_DEF && !det.valid && !ob_done
        |=> st.cfg.notch[0] == filt_pkg::NOTCH_RST && st.mode == filt_pkg::MODE_DEF)
        else $error("mode 5 defaults not restored");
    a_coef_hold: assert property (spd_in.valid |=> st.act_cfg == $past(st.act_cfg))
        else $error("coefficients changed during sample");
    a_vib_bypass: assert property (pos_in.valid && vib_bypass
        |=> pos_out.valid && pos_out.data == $past(pos_in.data)) else $error("position altered");
endmodule

/* rtl/svf_stage.sv */
`timescale 1ns/1ps
// Band-damp stage: state-variable core, output is input minus scaled bandpass.
module svf_stage #(
    parameter int unsigned FREQ_K = 3294,
    parameter int unsigned DAMP_K = 131
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic bypass,
    input wire logic signed [15:0] x,
    input wire logic [15:0] freq,
    input wire logic [13:0] dden,
    input wire logic [13:0] dnum,
    output logic signed [15:0] y
);
    typedef struct packed {
        logic signed [47:0] lp;
        logic signed [47:0] bp;
    } svf_state_type;
    localparam logic signed [47:0] DK = 48'(DAMP_K);
    svf_state_type st_r, st_nxt;
    logic [47:0] prod;
    logic signed [47:0] fc, dd, g, hp, yf;

    always_comb begin
        prod = 48'(freq) * 48'(FREQ_K);
        // Saturating the coefficient trades accuracy near Nyquist for stability.
        fc = (prod[47:9] > 39'h0000007FFF) ? 48'sh7FFF : 48'($signed({1'b0, prod[23:9]}));
        dd = 48'($signed({1'b0, dden}));
        g = 48'($signed({1'b0, dden})) - 48'($signed({1'b0, dnum}));
        hp = 48'(x) - st_r.lp - ((dd * DK * st_r.bp) >>> 16);
        st_nxt.bp = st_r.bp + ((fc * hp) >>> 15);
        st_nxt.lp = st_r.lp + ((fc * st_nxt.bp) >>> 15);
        yf = 48'(x) - ((g * DK * st_nxt.bp) >>> 16);
        if (bypass) begin
            y = x;
            st_nxt = '0;
        end else begin
            if (yf > 48'sh7FFF) begin
                y = 16'sh7FFF;
            end else if (yf < -48'sh8000) begin
                y = -16'sh8000;
            end else begin
                y = yf[15:0];
            end
            if (!en) begin
                st_nxt = st_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    a_bypass_pass: assert property (@(posedge pclk) disable iff (!presetn)
        bypass |-> y == x) else $error("bypassed stage alters sample");
    a_state_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !en && !bypass |=> st_r == $past(st_r)) else $error("state moved between samples");
endmodule

/* verif/loop_model.sv */
`timescale 1ns/1ps
// Speed and position loops: sparse sample pulses, so settings get idle cycles to load.
module loop_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [15:0] x,
    input wire filt_pkg::sample_type cur_out,
    input wire filt_pkg::sample_type pos_out,
    output filt_pkg::sample_type spd_in,
    output filt_pkg::sample_type pos_in,
    output logic [15:0] last_cur,
    output logic [15:0] last_pos,
    output logic [7:0] late_cnt
);
    logic [2:0] tick;
    logic [1:0] sent;
    logic fire;
    assign fire = run && (tick == 3'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 3'h0;
            sent <= 2'h0;
            spd_in <= '0;
            pos_in <= '0;
            last_cur <= 16'h0000;
            last_pos <= 16'h0000;
            late_cnt <= 8'h00;
        end else begin
            tick <= tick + 3'h1;
            spd_in.valid <= fire;
            pos_in.valid <= fire;
            // Between samples the data lines toggle, so stale data is never mistaken for valid.
            spd_in.data <= fire ? x : ~spd_in.data;
            pos_in.data <= fire ? x : ~pos_in.data;
            sent <= {pos_in.valid, spd_in.valid};
            if (sent[0] != cur_out.valid || sent[1] != pos_out.valid) begin
                late_cnt <= late_cnt + 8'h01;
            end
            if (cur_out.valid) begin
                last_cur <= cur_out.data;
            end
            if (pos_out.valid) begin
                last_pos <= pos_out.data;
            end
        end
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ob_done = 1'b0, ob_ok = 1'b0, run = 1'b0;
    filt_pkg::sample_type spd_in, pos_in, cur_out, pos_out;
    filt_pkg::det_type det = '0;
    logic [15:0] last_cur, last_pos;
    logic [7:0] late_cnt;
    int error_cnt = 0, check_count = 0;
    always #25 pclk = ~pclk;
    servo_filters dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spd_in(spd_in), .pos_in(pos_in), .det(det), .ob_done(ob_done),
        .ob_ok(ob_ok), .cur_out(cur_out), .pos_out(pos_out));
    loop_model loops (.pclk(pclk), .presetn(presetn), .run(run), .x(16'h1234),
        .cur_out(cur_out), .pos_out(pos_out), .spd_in(spd_in), .pos_in(pos_in),
        .last_cur(last_cur), .last_pos(last_pos), .late_cnt(late_cnt));
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // The request stands until the rising edge that samples pready high; the answer is taken there.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                conclude();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
        chk("err", {31'h0, er}, 32'h0);
    endtask
    task automatic pulse_det(input logic [15:0] f);
        @(posedge pclk);
        det <= '{valid: 1'b1, freq: f};
        @(posedge pclk);
        det <= '0;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc("mode", filt_pkg::A_MODE, 32'h0);
        rc("obcfg", filt_pkg::A_OBCFG, 32'h2);
        rc("rtcfg", filt_pkg::A_RTCFG, 32'h4C);
        rc("act", filt_pkg::A_ACT, 32'h1);
        rc("lp", filt_pkg::A_LPCOEF, 32'h7FFF);
        for (int i = 0; i < 12; i += 4) begin
            rc("den_f", 8'h20 + 8'(i * 4), 32'h7D0);
            rc("den_d", 8'h24 + 8'(i * 4), 32'h12C);
            rc("num_f", 8'h28 + 8'(i * 4), 32'h7D0);
            rc("num_d", 8'h2C + 8'(i * 4), 32'h00A);
        end
        rc("ven", filt_pkg::A_VEN, 32'h0);
        rc("vtype", filt_pkg::A_VTYPE, 32'h0);
        rc("vfreq", filt_pkg::A_VFREQ, 32'h2);
        rc("vdamp", filt_pkg::A_VDAMP, 32'h3);
        rc("cmode", filt_pkg::A_CMODE, 32'h0);
        apb(1'b0, 8'h70, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk("misaligned", {rd[30:0], er}, 32'h1);
        // Real-time tracking: band edges accepted, just outside refused, notch 2 moves and notch 3 stays.
        apb(1'b1, filt_pkg::A_MODE, 32'h3);
        pulse_det(16'h01F4);
        rc("rt lo", 8'h20, 32'h1F4);
        rc("rt num", 8'h28, 32'h1F4);
        rc("rt act", filt_pkg::A_ACT, 32'h3);
        pulse_det(16'h01F3);
        rc("below", 8'h20, 32'h1F4);
        pulse_det(16'h0BB8);
        rc("rt hi", 8'h20, 32'hBB8);
        pulse_det(16'h0BB9);
        rc("above", 8'h20, 32'hBB8);
        rc("det", filt_pkg::A_DET, 32'hBB8);
        rc("n3 kept", 8'h30, 32'h7D0);
        apb(1'b1, filt_pkg::A_RTCFG, 32'h0C);
        pulse_det(16'h0640);
        rc("rt off", 8'h20, 32'hBB8);
        // One-button: a detection while bit 1 is clear must not take a slot.
        apb(1'b1, filt_pkg::A_ACT, 32'h1);
        apb(1'b1, filt_pkg::A_MODE, 32'h1);
        apb(1'b1, filt_pkg::A_OBCFG, 32'h0);
        pulse_det(16'h0578);
        apb(1'b1, filt_pkg::A_OBCFG, 32'h2);
        pulse_det(16'h0640);
        pulse_det(16'h0708);
        rc("ob wait", 8'h30, 32'h7D0);
        @(posedge pclk);
        ob_done <= 1'b1;
        ob_ok <= 1'b1;
        @(posedge pclk);
        ob_done <= 1'b0;
        ob_ok <= 1'b0;
        rc("ob n2", 8'h20, 32'h640);
        rc("ob n3", 8'h30, 32'h708);
        rc("ob n4", 8'h40, 32'h7D0);
        apb(1'b1, filt_pkg::A_MODE, 32'h0);
        rc("kept act", filt_pkg::A_ACT, 32'h7);
        apb(1'b1, filt_pkg::A_MODE, 32'h2);
        rc("mode 2", filt_pkg::A_MODE, 32'h0);
        apb(1'b1, filt_pkg::A_MODE, 32'h5);
        rc("def n2", 8'h20, 32'h7D0);
        rc("def act", filt_pkg::A_ACT, 32'h1);
        // Manual notch 3: 600 Hz centre, 120 Hz wide, depth -20 dB.
        apb(1'b1, filt_pkg::A_MODE, 32'h0);
        apb(1'b1, 8'h30, 32'h4B0);
        apb(1'b1, 8'h38, 32'h4B0);
        apb(1'b1, 8'h34, 32'h064);
        apb(1'b1, 8'h3C, 32'h00A);
        rc("man d", 8'h34, 32'h064);
        rc("man n", 8'h3C, 32'h00A);
        // Vibration filter set up before it is enabled.
        apb(1'b1, filt_pkg::A_VTYPE, 32'h1);
        apb(1'b1, filt_pkg::A_VFREQ, 32'h7D);
        apb(1'b1, filt_pkg::A_VDAMP, 32'h63);
        apb(1'b1, filt_pkg::A_VEN, 32'h1);
        rc("vtype1", filt_pkg::A_VTYPE, 32'h1);
        rc("vfreq", filt_pkg::A_VFREQ, 32'h7D);
        rc("vdamp", filt_pkg::A_VDAMP, 32'h63);
        rc("ven1", filt_pkg::A_VEN, 32'h1);
        // Outside internal positioning and with no stage active, samples pass unchanged.
        apb(1'b1, filt_pkg::A_ACT, 32'h0);
        rc("act0", filt_pkg::A_ACT, 32'h0);
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b1, filt_pkg::A_LPCOEF, 32'h4000);
        repeat (20) @(posedge pclk);
        chk("cur", {16'h0, last_cur}, 32'h1234);
        chk("pos", {16'h0, last_pos}, 32'h1234);
        chk("late", {24'h0, late_cnt}, 32'h0);
        rc("lp new", filt_pkg::A_LPCOEF, 32'h4000);
        conclude();
    end
endmodule
